// ---- core/swem_pkg.sv ----
// Function
// RULE_01: Read scratchpad streams data bytes, wrap 1F.
// RULE_02: Copy scratchpad with key A5 programs data.
// RULE_03: Master releases line 100 ms after copy.
// RULE_04: Master preloads scratchpad before partial update.
// RULE_05: Read memory loads EEPROM into scratchpad.
// RULE_06: Read memory takes address, streams, wraps 1F.
// RULE_07: Reset after read memory keeps the transfer.
// RULE_08: Write app register stores bytes, wrap 07.
// RULE_09: Locked app register discards written bytes.
// RULE_10: Status read needs key 00 first.
// RULE_11: Status FF unlocked, FC locked.
// RULE_12: App read from scratchpad, EEPROM once locked.
// RULE_13: App read takes address, wraps 07.
// RULE_14: Copy-and-lock with A5 programs app, locks.
// RULE_15: Once locked, refuse writes and relock.
// RULE_16: Master releases line 100 ms after lock.
// RULE_17: Data memory is 32 bytes, 00 to 1F.
// RULE_18: App register is 8 bytes, 00 to 07.
// RULE_19: Write scratchpad stores bytes, wrap 1F.
// RULE_20: All bytes travel least significant bit first.
// RULE_21: Reset, presence, ROM select before each command.
// RULE_22: ROM command CC selects the single slave.
// RULE_23: Wrong key programs nothing, waits for reset.
// RULE_24: Unknown command ignored until next reset.
package swem_pkg;
   localparam logic [7:0] ROM_SKIP = 8'hcc;
   localparam logic [7:0] CMD_WR_SP = 8'h0f;
   localparam logic [7:0] CMD_RD_SP = 8'haa;
   localparam logic [7:0] CMD_CP_SP = 8'h55;
   localparam logic [7:0] CMD_RD_MEM = 8'hf0;
   localparam logic [7:0] CMD_WR_APP = 8'h99;
   localparam logic [7:0] CMD_RD_STAT = 8'h66;
   localparam logic [7:0] CMD_RD_APP = 8'hc3;
   localparam logic [7:0] CMD_CP_LOCK = 8'h5a;
   localparam logic [7:0] KEY_COPY = 8'ha5;
   localparam logic [7:0] KEY_STAT = 8'h00;
   localparam logic [7:0] STAT_UNLOCKED = 8'hff;
   localparam logic [7:0] STAT_LOCKED = 8'hfc;
   localparam logic [7:0] EEPROM_RST = 8'hff;
   localparam int DATA_BYTES = 32;
   localparam int APP_BYTES = 8;
   localparam int CLK_MHZ = 50;
   localparam int SLOT_US = 60;
   localparam int REC_US = 1;
   localparam int PRES_US = 60;
   localparam int PRWIN_US = 480;
   localparam int HOLD_MS = 100;
   localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
   localparam int REC_CYC = REC_US * CLK_MHZ;
   localparam int PRES_CYC = PRES_US * CLK_MHZ;
   localparam int PRWIN_CYC = PRWIN_US * CLK_MHZ;
   localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
   localparam logic [1:0] OP_RESET = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_HOLD = 2'h3;
endpackage

// ---- core/swem_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface swem_link_if;
   logic busRst;
   logic slotStb;
   logic mstOut;
   logic mstOe;
   logic devOut;
   logic devOe;
   logic line;
   // Open-drain wire with pull-up: low while either end drives
   assign line = !((mstOe && !mstOut) || (devOe && !devOut));
   modport master (output busRst, output slotStb, output mstOut,
      output mstOe, input line);
   modport device (input busRst, input slotStb, output devOut,
      output devOe, input line);
endinterface
`default_nettype wire

// ---- core/swem_device.sv ----
`timescale 1ns/1ns
`default_nettype none
module swem_device #(
   parameter int PRES_CYC = swem_pkg::PRES_CYC
) (
   input wire logic clk, // System clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   swem_link_if.device link, // Single-wire link
   output logic locked, // App register locked
   output logic dataProg, // Pulse: data EEPROM programmed
   output logic appProg, // Pulse: app EEPROM programmed
   output logic halted // Waiting for bus reset
);
   typedef enum logic [3:0] {
      S_IDLE, S_ROM, S_CMD, S_ADDR, S_KEY, S_WRITE, S_READ, S_STAT, S_HALT
   } swem_dst_t;

   swem_dst_t st_r;
   logic [7:0] dsp [swem_pkg::DATA_BYTES]; // RULE_17
   logic [7:0] deep [swem_pkg::DATA_BYTES];
   logic [7:0] asp [swem_pkg::APP_BYTES]; // RULE_18
   logic [7:0] aeep [swem_pkg::APP_BYTES];
   logic [7:0] cmd_r;
   logic [4:0] addr_r;
   logic [7:0] rxSh_r;
   logic [7:0] txSh_r;
   logic [2:0] bitCnt_r;
   logic [11:0] presCnt_r;
   logic locked_r;
   logic devOe_r;
   logic dataProg_r;
   logic appProg_r;
   logic halted_r;
   logic [7:0] rxByte;
   logic byteEnd;
   logic [4:0] addrNxt;

   function automatic logic isApp(input logic [7:0] c);
      return c == swem_pkg::CMD_WR_APP || c == swem_pkg::CMD_RD_APP;
   endfunction

   function automatic logic isRead(input logic [7:0] c);
      return c == swem_pkg::CMD_RD_SP || c == swem_pkg::CMD_RD_MEM ||
         c == swem_pkg::CMD_RD_APP;
   endfunction

   // Next wrapped address for the current command
   function automatic logic [4:0] wrapInc(input logic [7:0] c,
      input logic [4:0] a);
      logic [4:0] n;
      n = a + 5'h01; // RULE_01 RULE_06 RULE_19
      if (isApp(c)) begin
         n = {2'h0, n[2:0]}; // RULE_08 RULE_13
      end
      return n;
   endfunction

   assign rxByte = {link.line, rxSh_r[7:1]}; // RULE_20
   assign byteEnd = link.slotStb && bitCnt_r == 3'h7;
   assign addrNxt = wrapInc(cmd_r, addr_r);

   // Byte to return for the current read command
   function automatic logic [7:0] rdByte(input logic [7:0] c,
      input logic [4:0] a);
      logic [7:0] d;
      d = dsp[a]; // RULE_01 RULE_06
      if (isApp(c)) begin
         d = locked_r ? aeep[a[2:0]] : asp[a[2:0]]; // RULE_12
      end
      return d;
   endfunction

   // Command sequencer
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= S_IDLE;
         cmd_r <= 8'h00;
      end else if (ce) begin
         if (link.busRst) begin
            st_r <= S_ROM; // RULE_21
         end else if (byteEnd) begin
            case (st_r)
               S_ROM: begin
                  st_r <= (rxByte == swem_pkg::ROM_SKIP) ? S_CMD : S_HALT; // RULE_22
               end
               S_CMD: begin
                  cmd_r <= rxByte;
                  case (rxByte)
                     swem_pkg::CMD_WR_SP, swem_pkg::CMD_RD_SP,
                     swem_pkg::CMD_RD_MEM, swem_pkg::CMD_WR_APP,
                     swem_pkg::CMD_RD_APP: begin
                        st_r <= S_ADDR;
                     end
                     swem_pkg::CMD_CP_SP, swem_pkg::CMD_CP_LOCK,
                     swem_pkg::CMD_RD_STAT: begin
                        st_r <= S_KEY;
                     end
                     default: begin
                        st_r <= S_HALT; // RULE_24
                     end
                  endcase
               end
               S_ADDR: begin
                  st_r <= isRead(cmd_r) ? S_READ : S_WRITE;
               end
               S_KEY: begin
                  st_r <= (cmd_r == swem_pkg::CMD_RD_STAT &&
                     rxByte == swem_pkg::KEY_STAT) ? S_STAT : S_HALT; // RULE_10 RULE_23
               end
               S_STAT: begin
                  st_r <= S_HALT; // RULE_21
               end
               default: begin
                  st_r <= st_r;
               end
            endcase
         end
      end
   end

   // Bit counter and LSB-first shifters
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bitCnt_r <= 3'h0;
         rxSh_r <= 8'h00;
         txSh_r <= 8'h00;
      end else if (ce) begin
         if (link.busRst) begin
            bitCnt_r <= 3'h0;
         end else if (link.slotStb) begin
            bitCnt_r <= bitCnt_r + 3'h1;
            rxSh_r <= rxByte; // RULE_20
            txSh_r <= {1'b1, txSh_r[7:1]}; // RULE_20
            if (byteEnd && st_r == S_ADDR && isRead(cmd_r)) begin
               txSh_r <= rdByte(cmd_r, isApp(cmd_r) ?
                  {2'h0, rxByte[2:0]} : rxByte[4:0]);
            end else if (byteEnd && st_r == S_READ) begin
               txSh_r <= rdByte(cmd_r, addrNxt);
            end else if (byteEnd && st_r == S_KEY) begin
               txSh_r <= locked_r ? swem_pkg::STAT_LOCKED :
                  swem_pkg::STAT_UNLOCKED; // RULE_11
            end
         end
      end
   end

   // Address pointer
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         addr_r <= 5'h00;
      end else if (ce && !link.busRst && byteEnd) begin
         if (st_r == S_ADDR) begin
            addr_r <= isApp(cmd_r) ? {2'h0, rxByte[2:0]} : rxByte[4:0];
         end else if (st_r == S_WRITE || st_r == S_READ) begin
            addr_r <= addrNxt;
         end
      end
   end

   // Scratchpads, EEPROM arrays and lock
   always_ff @(posedge clk) begin
      // Pulses hold while the clock enable is low
      if (ce || !rst_b) begin
         dataProg_r <= 1'b0;
         appProg_r <= 1'b0;
      end
      if (!rst_b) begin
         locked_r <= 1'b0;
         for (int i = 0; i < swem_pkg::DATA_BYTES; i++) begin
            dsp[i] <= swem_pkg::EEPROM_RST;
            deep[i] <= swem_pkg::EEPROM_RST;
         end
         for (int i = 0; i < swem_pkg::APP_BYTES; i++) begin
            asp[i] <= swem_pkg::EEPROM_RST;
            aeep[i] <= swem_pkg::EEPROM_RST;
         end
      end else if (ce && !link.busRst && byteEnd) begin
         if (st_r == S_CMD && rxByte == swem_pkg::CMD_RD_MEM) begin
            dsp <= deep; // RULE_05 RULE_07
         end
         if (st_r == S_WRITE && cmd_r == swem_pkg::CMD_WR_SP) begin
            dsp[addr_r] <= rxByte; // RULE_19
         end
         if (st_r == S_WRITE && cmd_r == swem_pkg::CMD_WR_APP &&
            !locked_r) begin
            asp[addr_r[2:0]] <= rxByte; // RULE_08 RULE_09 RULE_15
         end
         if (st_r == S_KEY && rxByte == swem_pkg::KEY_COPY) begin
            if (cmd_r == swem_pkg::CMD_CP_SP) begin
               deep <= dsp; // RULE_02
               dataProg_r <= 1'b1;
            end
            if (cmd_r == swem_pkg::CMD_CP_LOCK && !locked_r) begin
               aeep <= asp; // RULE_14 RULE_15
               locked_r <= 1'b1;
               appProg_r <= 1'b1;
            end
         end
      end
   end

   // Presence pulse and read-slot drive
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         presCnt_r <= 12'h000;
         devOe_r <= 1'b0;
      end else if (ce) begin
         if (link.busRst) begin
            presCnt_r <= 12'(PRES_CYC);
         end else if (presCnt_r != 12'h000) begin
            presCnt_r <= presCnt_r - 12'h001;
         end
         devOe_r <= presCnt_r != 12'h000 ||
            ((st_r == S_READ || st_r == S_STAT) && !txSh_r[0]); // RULE_20
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         halted_r <= 1'b0;
      end else if (ce) begin
         halted_r <= st_r == S_HALT;
      end
   end

   assign link.devOut = 1'b0;
   assign link.devOe = devOe_r;
   assign locked = locked_r;
   assign dataProg = dataProg_r;
   assign appProg = appProg_r;
   assign halted = halted_r;
endmodule
`default_nettype wire

// ---- core/swem_master.sv ----
`timescale 1ns/1ns
`default_nettype none
module swem_master #(
   parameter int SLOT_CYC = swem_pkg::SLOT_CYC,
   parameter int REC_CYC = swem_pkg::REC_CYC,
   parameter int PRWIN_CYC = swem_pkg::PRWIN_CYC,
   parameter int HOLD_CYC = swem_pkg::HOLD_CYC
) (
   input wire logic clk, // System clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   swem_link_if.master link, // Single-wire link
   input wire logic opValid, // Operation request
   input wire logic [1:0] opCode, // Reset, write, read or hold
   input wire logic [7:0] opData, // Byte to write
   output logic opReady, // Idle, accepts a request
   output logic opDone, // Pulse: operation finished
   output logic [7:0] rdData, // Byte read, LSB first
   output logic presence // Presence seen at last reset
);
   typedef enum logic [2:0] {
      M_IDLE, M_PRES, M_BIT, M_SAMP, M_GAP, M_HOLD
   } swem_mst_t;

   swem_mst_t st_r;
   logic [22:0] cnt_r;
   logic [2:0] bitCnt_r;
   logic [7:0] sh_r;
   logic isWr_r;
   logic mstOe_r;
   logic busRst_r;
   logic slotStb_r;
   logic opDone_r;
   logic presence_r;
   logic [7:0] rdData_r;
   logic opReady_r;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= M_IDLE;
         cnt_r <= 23'h000000;
         bitCnt_r <= 3'h0;
         sh_r <= 8'h00;
         isWr_r <= 1'b0;
         mstOe_r <= 1'b0;
         busRst_r <= 1'b0;
         slotStb_r <= 1'b0;
         opDone_r <= 1'b0;
         presence_r <= 1'b0;
         rdData_r <= 8'h00;
         opReady_r <= 1'b1;
      end else if (ce) begin
         busRst_r <= 1'b0;
         slotStb_r <= 1'b0;
         opDone_r <= 1'b0;
         // Ready in every cycle whose next state is idle
         opReady_r <= (st_r == M_IDLE && !opValid) ||
            (cnt_r == 23'h000000 && (st_r == M_PRES ||
            st_r == M_HOLD || (st_r == M_GAP && bitCnt_r == 3'h7)));
         case (st_r)
            M_IDLE: begin
               if (opValid) begin
                  bitCnt_r <= 3'h0;
                  isWr_r <= opCode == swem_pkg::OP_WRITE;
                  sh_r <= (opCode == swem_pkg::OP_WRITE) ? opData : 8'hff;
                  case (opCode)
                     swem_pkg::OP_RESET: begin
                        busRst_r <= 1'b1; // RULE_21
                        presence_r <= 1'b0;
                        cnt_r <= 23'(PRWIN_CYC - 1);
                        st_r <= M_PRES;
                     end
                     swem_pkg::OP_HOLD: begin
                        cnt_r <= 23'(HOLD_CYC - 1); // RULE_03 RULE_16
                        st_r <= M_HOLD;
                     end
                     default: begin
                        mstOe_r <= opCode == swem_pkg::OP_WRITE &&
                           !opData[0]; // RULE_20
                        cnt_r <= 23'(SLOT_CYC - 2);
                        st_r <= M_BIT;
                     end
                  endcase
               end
            end
            M_PRES: begin
               if (!link.line) begin
                  presence_r <= 1'b1;
               end
               if (cnt_r == 23'h000000) begin
                  opDone_r <= 1'b1;
                  st_r <= M_IDLE;
               end else begin
                  cnt_r <= cnt_r - 23'h000001;
               end
            end
            M_BIT: begin
               if (cnt_r == 23'h000000) begin
                  slotStb_r <= 1'b1;
                  st_r <= M_SAMP;
               end else begin
                  cnt_r <= cnt_r - 23'h000001;
               end
            end
            M_SAMP: begin
               sh_r <= {link.line, sh_r[7:1]}; // RULE_20
               mstOe_r <= 1'b0;
               cnt_r <= 23'(REC_CYC - 1);
               st_r <= M_GAP;
            end
            M_GAP: begin
               if (cnt_r != 23'h000000) begin
                  cnt_r <= cnt_r - 23'h000001;
               end else if (bitCnt_r == 3'h7) begin
                  rdData_r <= sh_r;
                  opDone_r <= 1'b1;
                  st_r <= M_IDLE;
               end else begin
                  bitCnt_r <= bitCnt_r + 3'h1;
                  mstOe_r <= isWr_r && !sh_r[0]; // RULE_20
                  cnt_r <= 23'(SLOT_CYC - 2);
                  st_r <= M_BIT;
               end
            end
            M_HOLD: begin
               if (cnt_r == 23'h000000) begin
                  opDone_r <= 1'b1;
                  st_r <= M_IDLE;
               end else begin
                  cnt_r <= cnt_r - 23'h000001;
               end
            end
            default: begin
               st_r <= M_IDLE;
            end
         endcase
      end
   end

   assign link.busRst = busRst_r;
   assign link.slotStb = slotStb_r;
   assign link.mstOut = 1'b0;
   assign link.mstOe = mstOe_r;
   assign opReady = opReady_r;
   assign opDone = opDone_r;
   assign rdData = rdData_r;
   assign presence = presence_r;
endmodule
`default_nettype wire

// ---- tb/swem_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module swem_checker (
   input wire logic clk, // System clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic busRst, // Bus reset pulse
   input wire logic slotStb, // Bit sample strobe
   input wire logic mstOut, // Master data out
   input wire logic mstOe, // Master pulls low
   input wire logic devOut, // Device data out
   input wire logic devOe, // Device pulls low
   input wire logic line // Wire level
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_b |=> !mstOe && !devOe && !busRst && !slotStb)
      else $error("link not quiet after reset");
   a_wire_and: assert property (
      line == !((mstOe && !mstOut) || (devOe && !devOut)))
      else $error("wire level wrong");
   a_open_drain: assert property (!mstOut && !devOut)
      else $error("pin driven high");
   a_presence_pulse: assert property (
      busRst |-> ##[1:4] devOe [*8])
      else $error("no presence after bus reset");
   a_reset_single: assert property (
      busRst |=> (!busRst && !slotStb) [*8])
      else $error("bus reset not a lone pulse");
   a_slot_spacing: assert property (
      slotStb |=> !slotStb [*8])
      else $error("slots too close");
   a_bit_settled: assert property (
      slotStb |-> $stable(mstOe) && $stable(devOe))
      else $error("bit changed at sample point");
   a_master_recovers: assert property (slotStb |-> ##2 !mstOe)
      else $error("no recovery after slot");
   a_dev_quiet_write: assert property (
      slotStb && mstOe |-> !devOe)
      else $error("device drives in write slot");
endmodule
`default_nettype wire

// ---- tb/single_wire_eeprom_mem_cmds_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module single_wire_eeprom_mem_cmds_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic opValid = 1'b0;
   logic [1:0] opCode = 2'h0;
   logic [7:0] opData = 8'h00;
   logic opReady, opDone, presence, locked, dataProg, appProg, halted;
   logic [7:0] rdData;
   logic [7:0] dSp[32], dEe[32], aSp[8], aEe[8];
   logic lockM = 1'b0;
   logic ce = 1'b1;
   localparam int HOLD_T = 200;
   int failCount = 0;
   int testsRun = 0;
   int dProgs = 0;
   int aProgs = 0;
   int seed = 32'hd8f74b88;

   swem_link_if link();
   swem_master #(.SLOT_CYC(8), .REC_CYC(2), .PRWIN_CYC(50),
      .HOLD_CYC(HOLD_T)) i_swem_master (.clk(clk), .rst_b(rst_b),
      .ce(ce), .link(link), .opValid(opValid), .opCode(opCode),
      .opData(opData), .opReady(opReady), .opDone(opDone),
      .rdData(rdData), .presence(presence));
   swem_device #(.PRES_CYC(20)) i_swem_device (.clk(clk),
      .rst_b(rst_b), .ce(ce), .link(link), .locked(locked),
      .dataProg(dataProg), .appProg(appProg), .halted(halted));
   swem_checker i_swem_checker (.clk(clk), .rst_b(rst_b),
      .busRst(link.busRst), .slotStb(link.slotStb),
      .mstOut(link.mstOut), .mstOe(link.mstOe), .devOut(link.devOut),
      .devOe(link.devOe), .line(link.line));

   initial begin
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      if (dataProg === 1'b1)
         dProgs <= dProgs + 1;
      if (appProg === 1'b1)
         aProgs <= aProgs + 1;
   end

   task automatic wrapUp;
      $display("Checks %0d, mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
      input string what);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("MISMATCH %0t: %s got %h want %h", $time, what, got,
            exp);
      end
   endtask

   // One master operation; write slots and hold level are watched on the wire
   task automatic op(input logic [1:0] c, input logic [7:0] d);
      int n;
      int b;
      int en;
      n = 0;
      b = 0;
      en = 0;
      @(negedge clk);
      opValid = 1'b1;
      opCode = c;
      opData = d;
      @(negedge clk);
      opValid = 1'b0;
      opData = 8'($random(seed));
      chk({7'h00, opReady}, 8'h00, "busy after take");
      do begin
         @(negedge clk);
         n++;
         // Counts enabled edges; the hold is stretched by a random enable
         if (ce)
            en++;
         if (c == swem_pkg::OP_WRITE && link.slotStb === 1'b1 && b < 8) begin
            chk({7'h00, link.line}, {7'h00, d[b]}, "wire bit");
            b++;
         end
         if (c == swem_pkg::OP_HOLD) begin
            chk({7'h00, link.line}, 8'h01, "hold level");
            ce = (opDone === 1'b1) ? 1'b1 : 1'($random(seed));
         end
      end while (opDone !== 1'b1 && n < 3000);
      chk({7'h00, opDone}, 8'h01, "op done");
      chk({7'h00, opReady}, 8'h01, "ready after done");
      if (c == swem_pkg::OP_HOLD)
         chk(8'(en), 8'(HOLD_T), "hold length");
   endtask

   task automatic cmd(input logic [7:0] c, input logic [7:0] a,
      input bit sendA);
      op(swem_pkg::OP_RESET, 8'h00);
      chk({7'h00, presence}, 8'h01, "presence");
      op(swem_pkg::OP_WRITE, swem_pkg::ROM_SKIP);
      op(swem_pkg::OP_WRITE, c);
      if (sendA)
         op(swem_pkg::OP_WRITE, a);
   endtask

   function automatic logic [7:0] expRd(input logic [7:0] c,
      input int a, input int i);
      case (c)
         swem_pkg::CMD_RD_SP, swem_pkg::CMD_RD_MEM: return dSp[(a + i) % 32];
         swem_pkg::CMD_RD_APP: return lockM ? aEe[(a + i) % 8]
            : aSp[(a + i) % 8];
         swem_pkg::CMD_RD_STAT: return (i != 0 ||
            a != swem_pkg::KEY_STAT) ? 8'hff : lockM ?
            swem_pkg::STAT_LOCKED : swem_pkg::STAT_UNLOCKED;
         default: return 8'hff;
      endcase
   endfunction

   task automatic wrs(input logic [7:0] c, input logic [7:0] a,
      input int n);
      logic [7:0] v;
      cmd(c, a, 1'b1);
      for (int i = 0; i < n; i++) begin
         v = 8'($random(seed));
         op(swem_pkg::OP_WRITE, v);
         if (c == swem_pkg::CMD_WR_SP)
            dSp[(a + i) % 32] = v;
         if (c == swem_pkg::CMD_WR_APP && !lockM)
            aSp[(a + i) % 8] = v;
      end
   endtask

   task automatic rds(input logic [7:0] c, input logic [7:0] a,
      input int n);
      cmd(c, a, 1'b1);
      if (c == swem_pkg::CMD_RD_MEM)
         dSp = dEe;
      for (int i = 0; i < n; i++) begin
         op(swem_pkg::OP_READ, 8'hff);
         chk(rdData, expRd(c, a, i), "read");
      end
   endtask

   initial begin
      #1000000;
      failCount++;
      $display("MISMATCH %0t: run did not finish", $time);
      wrapUp();
   end

   initial begin
      foreach (dSp[i]) dSp[i] = 8'hff;
      dEe = dSp;
      foreach (aSp[i]) aSp[i] = 8'hff;
      aEe = aSp;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      wrs(swem_pkg::CMD_WR_SP, 8'h1e, 3);
      rds(swem_pkg::CMD_RD_SP, 8'h1e, 3);
      rds(swem_pkg::CMD_RD_MEM, 8'h1f, 2);
      wrs(swem_pkg::CMD_WR_SP, 8'h00, 32);
      cmd(swem_pkg::CMD_CP_SP, 8'h5a, 1'b1);
      chk(8'(dProgs), 8'h00, "bad key copy");
      chk({7'h00, halted}, 8'h01, "halt on bad key");
      cmd(swem_pkg::CMD_CP_SP, swem_pkg::KEY_COPY, 1'b1);
      op(swem_pkg::OP_HOLD, 8'h00);
      dEe = dSp;
      chk(8'(dProgs), 8'h01, "copy");
      wrs(swem_pkg::CMD_WR_SP, 8'h04, 2);
      cmd(swem_pkg::CMD_RD_MEM, 8'h00, 1'b0);
      dSp = dEe;
      rds(swem_pkg::CMD_RD_SP, 8'h03, 4);
      rds(swem_pkg::CMD_RD_MEM, 8'($random(seed)), 3);
      rds(swem_pkg::CMD_RD_STAT, swem_pkg::KEY_STAT, 2);
      wrs(swem_pkg::CMD_WR_APP, 8'h06, 3);
      rds(swem_pkg::CMD_RD_APP, 8'h06, 9);
      cmd(swem_pkg::CMD_CP_LOCK, swem_pkg::KEY_COPY, 1'b1);
      op(swem_pkg::OP_HOLD, 8'h00);
      aEe = aSp;
      lockM = 1'b1;
      chk(8'(aProgs), 8'h01, "lock copy");
      chk({7'h00, locked}, 8'h01, "locked");
      wrs(swem_pkg::CMD_WR_APP, 8'h00, 8);
      rds(swem_pkg::CMD_RD_APP, 8'h02, 8);
      rds(swem_pkg::CMD_RD_STAT, swem_pkg::KEY_STAT, 1);
      rds(swem_pkg::CMD_RD_STAT, 8'h01, 1);
      cmd(swem_pkg::CMD_CP_LOCK, swem_pkg::KEY_COPY, 1'b1);
      op(swem_pkg::OP_HOLD, 8'h00);
      chk(8'(aProgs), 8'h01, "second lock");
      rds(8'h3c, 8'h00, 2);
      chk({7'h00, halted}, 8'h01, "halt on unknown");
      wrapUp();
   end
endmodule
`default_nettype wire
